// ==== pssr_params.svh ====
`ifndef PSSR_PARAMS_SVH
`define PSSR_PARAMS_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define PSSR_ADDR_W 15
`define PSSR_DATA_W 32
`define PSSR_LANES 4
`define PSSR_LANE_W 8
`define PSSR_DEPTH 32768
`define PSSR_CNT_W 2

// ----------------------------------------------------------------
// Reset and idle values
// ----------------------------------------------------------------
`define PSSR_ADDR_ZERO 15'h0000
`define PSSR_DATA_ZERO 32'h0000_0000
`define PSSR_LANE_ZERO 8'h00
`define PSSR_LANES_OFF 4'hF
`define PSSR_LANES_NONE 4'h0
`define PSSR_CNT_ZERO 2'h0
`define PSSR_CNT_ONE 2'h1

// ----------------------------------------------------------------
// Pin synchronisers: bit 0 output enable, bit 1 sleep, bit 2 order
// ----------------------------------------------------------------
`define PSSR_SYNC_N 3
`define PSSR_SYNC_OE 0
`define PSSR_SYNC_SLEEP 1
`define PSSR_SYNC_ORDER 2
`define PSSR_SYNC_RST 3'h5

`endif

// ==== pssr_pkg.sv ====
`include "pssr_params.svh"

package pssr_pkg;

  // ----------------------------------------------------------------
  // Data types
  // ----------------------------------------------------------------
  typedef logic [`PSSR_ADDR_W-1:0] pssr_addr_type;
  typedef logic [`PSSR_DATA_W-1:0] pssr_data_type;
  typedef logic [`PSSR_LANES-1:0] pssr_lane_type;
  typedef logic [`PSSR_CNT_W-1:0] pssr_cnt_type;
  typedef logic [`PSSR_SYNC_N-1:0] pssr_sync_type;

  // ----------------------------------------------------------------
  // Burst order and access operation
  // ----------------------------------------------------------------
  typedef enum logic {
    PSSR_LINEAR = 1'b0,
    PSSR_INTERLEAVED = 1'b1
  } pssr_order_type;

  typedef enum logic [1:0] {
    PSSR_OP_IDLE = 2'b00,
    PSSR_OP_READ = 2'b01,
    PSSR_OP_WRITE = 2'b10
  } pssr_op_type;

endpackage

// ==== pssr_burst_if.sv ====
`include "pssr_params.svh"

interface pssr_burst_if;
  import pssr_pkg::*;

  logic load;
  logic advance;
  pssr_cnt_type burst_start_bits;
  pssr_order_type order;
  pssr_cnt_type offset;

  modport ctl (
    output load,
    output advance,
    output burst_start_bits,
    output order,
    input offset
  );

  modport ctr (
    input load,
    input advance,
    input burst_start_bits,
    input order,
    output offset
  );

endinterface

// ==== pssr_burst_ctr.sv ====
`include "pssr_params.svh"

module pssr_burst_ctr (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Burst control
  pssr_burst_if.ctr burst
);
  import pssr_pkg::*;

  // ----------------------------------------------------------------
  // Burst count
  // ----------------------------------------------------------------
  pssr_cnt_type count_q;
  pssr_cnt_type count_d;
  pssr_cnt_type step;
  pssr_cnt_type linear_offset;
  pssr_cnt_type inter_offset;

  assign step = burst.advance ? pssr_cnt_type'(count_q + `PSSR_CNT_ONE) : count_q;
  assign count_d = burst.load ? `PSSR_CNT_ZERO : step;

  // ----------------------------------------------------------------
  // Address sequence
  // ----------------------------------------------------------------
  assign linear_offset = pssr_cnt_type'(burst.burst_start_bits + count_d);
  assign inter_offset = burst.burst_start_bits ^ count_d;
  assign burst.offset = (burst.order == PSSR_LINEAR) ? linear_offset : inter_offset;

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      count_q <= `PSSR_CNT_ZERO;
    end
    else
    begin
      count_q <= count_d;
    end
  end

endmodule

// ==== pssr_top.sv ====
`include "pssr_params.svh"

module pssr_top (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Address and strobes
  input wire pssr_pkg::pssr_addr_type addr_in,
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  // Chip enables
  input wire logic chip_sel_a_n_in,
  input wire logic chip_sel_b_in,
  input wire logic chip_sel_c_n_in,
  // Write controls
  input wire logic all_bytes_write_n_in,
  input wire logic lane_write_enable_n_in,
  input wire pssr_pkg::pssr_lane_type lane_select_n_in,
  // Asynchronous and static pins
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic burst_order_strap_in,
  // Data pins
  input wire pssr_pkg::pssr_data_type dq_in,
  output logic [`PSSR_DATA_W-1:0] dq_out,
  output logic dq_oe_out
);
  import pssr_pkg::*;

  // ----------------------------------------------------------------
  // Input registers
  // ----------------------------------------------------------------
  pssr_addr_type addr_q;
  logic proc_strobe_n_q;
  logic ctrl_strobe_n_q;
  logic advance_n_q;
  logic sel_a_n_q;
  logic sel_b_q;
  logic sel_c_n_q;
  logic all_write_n_q;
  logic lane_we_n_q;
  pssr_lane_type lane_sel_n_q;
  pssr_data_type wdata_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      proc_strobe_n_q <= 1'b1;
      ctrl_strobe_n_q <= 1'b1;
      advance_n_q <= 1'b1;
    end
    else
    begin
      proc_strobe_n_q <= proc_addr_strobe_n_in;
      ctrl_strobe_n_q <= ctrl_addr_strobe_n_in;
      advance_n_q <= burst_advance_n_in;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      sel_a_n_q <= 1'b1;
      sel_b_q <= 1'b0;
      sel_c_n_q <= 1'b1;
    end
    else
    begin
      sel_a_n_q <= chip_sel_a_n_in;
      sel_b_q <= chip_sel_b_in;
      sel_c_n_q <= chip_sel_c_n_in;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      all_write_n_q <= 1'b1;
      lane_we_n_q <= 1'b1;
      lane_sel_n_q <= `PSSR_LANES_OFF;
    end
    else
    begin
      all_write_n_q <= all_bytes_write_n_in;
      lane_we_n_q <= lane_write_enable_n_in;
      lane_sel_n_q <= lane_select_n_in;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      addr_q <= `PSSR_ADDR_ZERO;
      wdata_q <= `PSSR_DATA_ZERO;
    end
    else
    begin
      addr_q <= addr_in;
      wdata_q <= dq_in;
    end
  end

  // ----------------------------------------------------------------
  // Asynchronous pin synchronisers
  // ----------------------------------------------------------------
  localparam pssr_sync_type SyncRst = `PSSR_SYNC_RST;
  pssr_sync_type async_raw;
  pssr_sync_type sync1_q;
  pssr_sync_type sync2_q;
  pssr_sync_type sync3_q;
  pssr_sync_type async_q;

  assign async_raw = {burst_order_strap_in, sleep_request_in, output_enable_n_in};

  for (genvar s = 0; s < `PSSR_SYNC_N; s++)
  begin : g_sync
    always_ff @(posedge ref_clk_in)
    begin
      if (!reset_n_in)
      begin
        sync1_q[s] <= SyncRst[s];
        sync2_q[s] <= SyncRst[s];
        sync3_q[s] <= SyncRst[s];
        async_q[s] <= SyncRst[s];
      end
      else
      begin
        sync1_q[s] <= async_raw[s];
        sync2_q[s] <= sync1_q[s];
        sync3_q[s] <= sync2_q[s];
        if (sync2_q[s] == sync3_q[s])
        begin
          async_q[s] <= sync3_q[s];
        end
      end
    end
  end

  logic oe_n_s;
  logic sleep_s;
  pssr_order_type order_s;

  assign oe_n_s = async_q[`PSSR_SYNC_OE];
  assign sleep_s = async_q[`PSSR_SYNC_SLEEP];
  assign order_s = pssr_order_type'(async_q[`PSSR_SYNC_ORDER]);

  // ----------------------------------------------------------------
  // Strobe and selection decode
  // ----------------------------------------------------------------
  logic proc_strobe;
  logic ctrl_strobe;
  logic any_strobe;
  logic selected;
  logic active_q;
  logic active_d;
  logic access;

  assign proc_strobe = !proc_strobe_n_q && !sel_a_n_q;
  assign ctrl_strobe = !ctrl_strobe_n_q && !proc_strobe;
  assign any_strobe = proc_strobe || ctrl_strobe;
  assign selected = !sel_a_n_q && sel_b_q && !sel_c_n_q;
  assign active_d = any_strobe ? selected : active_q;
  assign access = active_d && !sleep_s;

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      active_q <= 1'b0;
    end
    else
    begin
      active_q <= active_d;
    end
  end

  // ----------------------------------------------------------------
  // Address register and burst counter
  // ----------------------------------------------------------------
  pssr_addr_type base_q;
  logic load;
  logic advance;
  pssr_addr_type acc_addr;

  pssr_burst_if burst ();

  assign load = any_strobe && selected;
  assign advance = !any_strobe && !advance_n_q && active_q && !sleep_s;
  assign burst.load = load;
  assign burst.advance = advance;
  assign burst.burst_start_bits = load ? addr_q[`PSSR_CNT_W-1:0] : base_q[`PSSR_CNT_W-1:0];
  assign burst.order = order_s;

  pssr_burst_ctr u_ctr (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .burst(burst)
  );

  // Current word: incoming address on a load, else stored upper bits with the counter's offset
  assign acc_addr = load ? addr_q : {base_q[`PSSR_ADDR_W-1:`PSSR_CNT_W], burst.offset};

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      base_q <= `PSSR_ADDR_ZERO;
    end
    else if (load)
    begin
      base_q <= addr_q;
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic global_write;
  logic lane_write;
  pssr_lane_type lane_mask;
  pssr_lane_type write_lanes;
  logic write;
  logic read;
  pssr_op_type op_d;

  assign global_write = !all_write_n_q;
  assign lane_write = !lane_we_n_q;
  assign lane_mask = global_write ? `PSSR_LANES_OFF :
                     (lane_write ? ~lane_sel_n_q : `PSSR_LANES_NONE);
  assign write = access && !proc_strobe && (lane_mask != `PSSR_LANES_NONE);
  assign write_lanes = write ? lane_mask : `PSSR_LANES_NONE;
  assign read = access && !write;
  assign op_d = write ? PSSR_OP_WRITE : (read ? PSSR_OP_READ : PSSR_OP_IDLE);

  // ----------------------------------------------------------------
  // Storage array, one bank per byte lane
  // ----------------------------------------------------------------
  pssr_data_type array_word;

  for (genvar l = 0; l < `PSSR_LANES; l++)
  begin : g_lane
    logic [`PSSR_LANE_W-1:0] bank [0:`PSSR_DEPTH-1];
    logic [`PSSR_LANE_W-1:0] rd_q;

    always_ff @(posedge ref_clk_in)
    begin
      if (write_lanes[l])
      begin
        bank[acc_addr] <= wdata_q[l*`PSSR_LANE_W +: `PSSR_LANE_W];
      end
    end

    always_ff @(posedge ref_clk_in)
    begin
      if (!reset_n_in)
      begin
        rd_q <= `PSSR_LANE_ZERO;
      end
      else if (read)
      begin
        rd_q <= bank[acc_addr];
      end
    end

    assign array_word[l*`PSSR_LANE_W +: `PSSR_LANE_W] = rd_q;
  end

  // ----------------------------------------------------------------
  // Array stage operation
  // ----------------------------------------------------------------
  pssr_op_type op1_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      op1_q <= PSSR_OP_IDLE;
    end
    else
    begin
      op1_q <= op_d;
    end
  end

  // ----------------------------------------------------------------
  // Output register and pin drive
  // ----------------------------------------------------------------
  logic have_read;
  logic drive_d;
  logic [`PSSR_DATA_W-1:0] dq_q;
  logic dq_oe_q;

  always_comb
  begin
    unique case (op1_q)
      PSSR_OP_IDLE:
      begin
        have_read = 1'b0;
      end
      PSSR_OP_READ:
      begin
        have_read = 1'b1;
      end
      PSSR_OP_WRITE:
      begin
        have_read = 1'b0;
      end
      default:
      begin
        have_read = 1'b0;
      end
    endcase
  end

  assign drive_d = have_read && !oe_n_s && !sleep_s;

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      dq_q <= `PSSR_DATA_ZERO;
    end
    else if (have_read)
    begin
      dq_q <= array_word;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      dq_oe_q <= 1'b0;
    end
    else
    begin
      dq_oe_q <= drive_d;
    end
  end

  assign dq_out = dq_q;
  assign dq_oe_out = dq_oe_q;

endmodule

// ==== pssr_asserts.sv ====
`include "pssr_params.svh"

module pssr_asserts (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Strobes, enables, writes
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic chip_sel_a_n_in,
  input wire logic chip_sel_b_in,
  input wire logic chip_sel_c_n_in,
  input wire logic all_bytes_write_n_in,
  input wire logic lane_write_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  // Data out
  input wire logic [`PSSR_DATA_W-1:0] dq_out,
  input wire logic dq_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import pssr_pkg::*;
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire sel_w = !chip_sel_a_n_in && chip_sel_b_in && !chip_sel_c_n_in;
  wire pstb_w = !proc_addr_strobe_n_in && !chip_sel_a_n_in;
  wire cstb_w = !ctrl_addr_strobe_n_in;
  wire desel_w = (pstb_w || cstb_w) && !sel_w;
  wire nolane_w = all_bytes_write_n_in && lane_write_enable_n_in;
  wire rd_w = (pstb_w || cstb_w) && sel_w && (pstb_w || nolane_w);
  wire wr_w = cstb_w && proc_addr_strobe_n_in && sel_w && !all_bytes_write_n_in;
  wire ign_w = !proc_addr_strobe_n_in && chip_sel_a_n_in && !cstb_w;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_quiet;
    (reset_n_in && !output_enable_n_in && !sleep_request_in) [*6];
  endsequence
  sequence s_read;
    s_quiet ##0 rd_w;
  endsequence
  property p_reset;
    disable iff (1'b0) !reset_n_in |=> !dq_oe_out && dq_out == `PSSR_DATA_ZERO;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_read_lat;
    s_read |-> ##3 dq_oe_out;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read word late or missing");
  property p_single;
    s_read ##1 desel_w |-> ##2 dq_oe_out ##1 !dq_oe_out;
  endproperty
  a_single: assert property (p_single) else $error("drive not one cycle per word");
  property p_desel;
    desel_w |-> ##3 !dq_oe_out;
  endproperty
  a_desel: assert property (p_desel) else $error("drive after deselect");
  property p_write;
    wr_w |-> ##3 !dq_oe_out;
  endproperty
  a_write: assert property (p_write) else $error("drive on write cycle");
  property p_proc_ign;
    desel_w ##1 ign_w |-> ##3 !dq_oe_out;
  endproperty
  a_proc_ign: assert property (p_proc_ign) else $error("strobe taken with enable a high");
  property p_oe_off;
    output_enable_n_in [*7] |-> !dq_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive with output enable high");
  property p_sleep;
    sleep_request_in [*7] |-> !dq_oe_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("drive during sleep");
endmodule

bind pssr_top pssr_asserts pssr_asserts_inst (.ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in), .proc_addr_strobe_n_in(proc_addr_strobe_n_in),
  .ctrl_addr_strobe_n_in(ctrl_addr_strobe_n_in), .chip_sel_a_n_in(chip_sel_a_n_in),
  .chip_sel_b_in(chip_sel_b_in), .chip_sel_c_n_in(chip_sel_c_n_in),
  .all_bytes_write_n_in(all_bytes_write_n_in),
  .lane_write_enable_n_in(lane_write_enable_n_in),
  .output_enable_n_in(output_enable_n_in), .sleep_request_in(sleep_request_in),
  .dq_out(dq_out), .dq_oe_out(dq_oe_out));

// ==== pssr_ctrl_model.sv ====
`include "pssr_params.svh"

module pssr_ctrl_model (
  // Clock
  input wire logic ref_clk_in,
  // Bus to memory
  output pssr_pkg::pssr_addr_type addr_out,
  output logic [10:0] ctl_out,
  output pssr_pkg::pssr_lane_type lane_select_n_out,
  output pssr_pkg::pssr_data_type wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import pssr_pkg::*;
  initial
  begin
    ctl_out = 11'h759;
    addr_out = `PSSR_ADDR_ZERO;
    lane_select_n_out = `PSSR_LANES_OFF;
    wdata_out = `PSSR_DATA_ZERO;
  end
  // ----------------------------------------------------------------
  // One bus cycle, launched just after the edge
  // ----------------------------------------------------------------
  task drive(input logic [10:0] c, input pssr_addr_type a, input pssr_lane_type ln,
    input pssr_data_type d, input logic wr);
    @(posedge ref_clk_in);
    ctl_out <= c;
    addr_out <= a;
    lane_select_n_out <= ln;
    wdata_out <= wr ? d : ~wdata_out;
  endtask
endmodule

// ==== test_pipelined_sync_burst_sram.sv ====
module test_pipelined_sync_burst_sram;
  timeunit 1ns;
  timeprecision 1ps;
  import pssr_pkg::*;
  localparam logic [10:0] I = 11'h759, PROC = 11'h400, CTRL = 11'h200, STEP = 11'h100;
  localparam logic [10:0] DA = 11'h080, ALLW = 11'h010, LWE = 11'h008, OEH = 11'h004;
  localparam logic [10:0] SLP = 11'h002, LIN = 11'h001;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  pssr_addr_type addr;
  logic [10:0] c;
  pssr_lane_type ln;
  pssr_data_type wd, rd;
  logic rd_oe;
  int num_errors = 0, comparisons = 0, cycles = 0, base = 0, n = 0, k, a;
  logic act = 1'b0;
  // Pins {oe_n, sleep}: three-cycle history and the value the block acts on
  logic [1:0] h1 = 2'b00, h2 = 2'b10, h3 = 2'b10, ef = 2'b10;
  logic [31:0] x = 32'h13, e;
  logic [10:0] m;
  logic [31:0] mem [int];
  int kq[$];
  logic [31:0] eq[$];
  pssr_top pssr_top_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .addr_in(addr),
    .proc_addr_strobe_n_in(c[10]), .ctrl_addr_strobe_n_in(c[9]), .burst_advance_n_in(c[8]),
    .chip_sel_a_n_in(c[7]), .chip_sel_b_in(c[6]), .chip_sel_c_n_in(c[5]),
    .all_bytes_write_n_in(c[4]), .lane_write_enable_n_in(c[3]), .lane_select_n_in(ln),
    .output_enable_n_in(c[2]), .sleep_request_in(c[1]), .burst_order_strap_in(c[0]),
    .dq_in(wd), .dq_out(rd), .dq_oe_out(rd_oe));
  pssr_ctrl_model pssr_ctrl_model_inst (.ref_clk_in(ref_clk_in), .addr_out(addr),
    .ctl_out(c), .lane_select_n_out(ln), .wdata_out(wd));
  initial
  begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Reference model of one cycle, then drive it
  task cyc(input logic [10:0] v, input int ad, input logic [3:0] lm);
    logic pw, wr, rdv;
    logic [1:0] en;
    int wa;
    logic [31:0] d;
    d = rnd();
    // A pin change counts once two samples agree, three cycles late
    ef = (ef & (h3 ^ h2)) | (h3 & ~(h3 ^ h2));
    en = (ef & (h2 ^ h1)) | (h2 & ~(h2 ^ h1));
    h3 = h2;
    h2 = h1;
    h1 = v[2:1];
    pw = !v[10] && !v[7];
    if (pw || !v[9])
    begin
      act = !v[7] && v[6] && !v[5];
      base = ad;
      n = 0;
    end
    else if (act && !v[8] && !ef[0])
      n = n + 1;
    wa = (base & 32'h7FFC) | (v[0] ? ((base ^ n) & 3) : ((base + n) & 3));
    wr = act && !ef[0] && !pw && (!v[4] || (!v[3] && lm != 4'hF));
    rdv = act && !ef[0] && !wr;
    pssr_ctrl_model_inst.drive(v, ad[14:0], lm, d, wr);
    for (int i = 0; i < 4; i++)
      if (wr && (!v[4] || !lm[i]))
        mem[wa][8*i +: 8] = d[8*i +: 8];
    kq.push_back(rdv ? ((en[1] || en[0]) ? 2 : 1) : 0);
    eq.push_back(rdv ? mem[wa] : 32'h0);
  endtask
  task idle(input int t, input logic [10:0] v);
    repeat (t) cyc(v, 0, 4'hF);
  endtask
  // ----------------------------------------------------------------
  // Output monitor and watchdog
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in)
  begin
    #1;
    if (kq.size() == 4)
    begin
      k = kq.pop_front();
      e = eq.pop_front();
      chk(32'(rd_oe), 32'(k == 1));
      if (k != 0)
        chk(rd, e);
    end
  end
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      end_sim;
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    for (int o = 0; o < 2; o++)
    begin
      m = o ? I ^ LIN : I;
      a = rnd() & 32'h7FFF;
      idle(6, m);
      cyc(m ^ CTRL ^ ALLW, a, 4'hF);
      repeat (3) cyc(m ^ STEP ^ ALLW, 0, 4'h0);
      for (int i = 0; i < 4; i++)
        cyc(m ^ CTRL ^ LWE, a, 4'hF ^ (4'h1 << i));
      cyc(m ^ CTRL, a, 4'h0);
      cyc(m ^ PROC ^ CTRL ^ ALLW, a, 4'hF);
      repeat (3) cyc(m ^ STEP, 0, 4'hF);
      cyc(m, 0, 4'hF);
      for (int i = 0; i < 3; i++)
      begin
        cyc(m ^ CTRL, a, 4'hF);
        cyc(m ^ CTRL ^ (DA >> i), a, 4'hF);
      end
      cyc(m ^ PROC ^ DA, a, 4'hF);
      idle(8, m ^ OEH);
      cyc(m ^ OEH ^ CTRL, a, 4'hF);
      idle(8, m ^ SLP);
      idle(6, m);
      cyc(m ^ CTRL ^ (DA >> 1), a, 4'hF);
    end
    idle(6, I);
    end_sim;
  end
endmodule
